// File: dv/line_error_jitter_status_regs_tb_top.sv
// Self-checking bench for the line error and jitter status register slice
`timescale 1ns/1ps
`include "line_err_params.svh"

module line_error_jitter_status_regs_tb_top;
    import line_err_pkg::*;
    typedef struct packed {
        logic [4:0] ev;
        logic [7:0] st;
    } row_type;
    // Short round keeps the run brief; expectations derive from it
    localparam int SEC = 16;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [`ADDR_W-1:0] i_addr = '0;
    logic [`DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [`DATA_W-1:0] o_rdata;
    line_event_type i_events = '0;
    logic i_err_pulse = 1'b0;
    jitter_ctrl_type o_jitter;
    logic o_irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_upd = 0;
    int base;
    logic [7:0] d;
    logic [`ADDR_W-1:0] raddr [5] = '{11'h022, 11'h023, 11'h024, 11'h7E5, 11'h02A};
    row_type rows [5] = '{'{5'h10, 8'h20}, '{5'h08, 8'h10}, '{5'h04, 8'h08},
        '{5'h02, 8'h04}, '{5'h01, 8'h02}};

    always #20 i_clk = ~i_clk;

    always @(posedge i_clk)
        if (o_jitter.update === 1'b1)
            n_upd <= n_upd + 1;

    line_error_jitter_status_regs #(
        .SECOND_CYCLES(SEC)
    ) dut (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_events(i_events),
        .i_err_pulse(i_err_pulse),
        .o_jitter(o_jitter),
        .o_irq(o_irq)
    );

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe; taken at its closing edge
    task automatic rd(input logic [`ADDR_W-1:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        v = o_rdata;
    endtask

    task automatic errs(input int n);
        @(posedge i_clk);
        i_err_pulse <= 1'b1;
        repeat (n) @(posedge i_clk);
        i_err_pulse <= 1'b0;
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #(40 * 90000);
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        repeat (16) @(posedge i_clk);
        chk("irq_in_reset", o_irq, 1'b0);
        i_reset <= 1'b0;
        foreach (raddr[k])
        begin
            rd(raddr[k], d);
            chk("reset_value", d, `RESET_BYTE);
        end
        // Pulsing every cycle makes each auto round hold exactly SEC errors
        @(posedge i_clk);
        i_err_pulse <= 1'b1;
        repeat (3 * SEC) @(posedge i_clk);
        rd(`OFF_COUNT_LOW, d);
        chk("auto_low", d, SEC);
        rd(`OFF_COUNT_HIGH, d);
        chk("auto_high", d, 8'h00);
        i_err_pulse <= 1'b0;
        foreach (rows[k])
        begin
            @(posedge i_clk);
            i_events <= rows[k].ev;
            @(posedge i_clk);
            i_events <= '0;
            wr(`OFF_IRQ_STATUS, ~rows[k].st);
            rd(`OFF_IRQ_STATUS, d);
            chk("status_set", d, rows[k].st);
            chk("irq_set", o_irq, 1'b1);
            wr(`OFF_IRQ_STATUS, rows[k].st);
            rd(`OFF_IRQ_STATUS, d);
            chk("status_clr", d, 8'h00);
            chk("irq_clr", o_irq, 1'b0);
        end
        wr(`OFF_IRQ_MASK, 8'h20);
        @(posedge i_clk);
        i_events <= 5'h10;
        @(posedge i_clk);
        i_events <= '0;
        @(posedge i_clk);
        chk("irq_masked", o_irq, 1'b0);
        wr(`OFF_IRQ_MASK, 8'h00);
        @(posedge i_clk);
        chk("irq_unmasked", o_irq, 1'b1);
        wr(`OFF_IRQ_STATUS, 8'hFF);
        rd(`OFF_IRQ_STATUS, d);
        chk("reserved_zero", d, 8'h00);
        rd(11'h100, d);
        chk("unmapped", d, 8'h00);
        wr(`OFF_COUNT_CTRL, 8'h02);
        wr(`OFF_COUNT_CTRL, 8'h03);
        errs(291);
        wr(`OFF_COUNT_CTRL, 8'h03);
        wr(`OFF_COUNT_LOW, 8'hAA);
        rd(`OFF_COUNT_LOW, d);
        chk("man_low", d, 8'h23);
        rd(`OFF_COUNT_HIGH, d);
        chk("man_high", d, 8'h01);
        // One short of the overflow must not flag it
        errs(65535);
        rd(`OFF_IRQ_STATUS, d);
        chk("no_ovf", d, 8'h00);
        errs(1);
        rd(`OFF_IRQ_STATUS, d);
        chk("ovf", d, 8'h01);
        chk("irq_ovf", o_irq, 1'b1);
        wr(`OFF_COUNT_CTRL, 8'h03);
        rd(`OFF_COUNT_LOW, d);
        chk("sat_low", d, 8'hFF);
        rd(`OFF_COUNT_HIGH, d);
        chk("sat_high", d, 8'hFF);
        wr(`OFF_IRQ_STATUS, 8'h01);
        base = n_upd;
        wr(`OFF_JIT_CONFIG, 8'h04);
        repeat (4) @(posedge i_clk);
        chk("stop_rise", n_upd - base, 16'h1);
        wr(`OFF_JIT_CONFIG, 8'h04);
        repeat (4) @(posedge i_clk);
        chk("stop_held", n_upd - base, 16'h1);
        wr(`OFF_JIT_CONFIG, 8'h00);
        wr(`OFF_JIT_CONFIG, 8'h04);
        repeat (4) @(posedge i_clk);
        chk("stop_again", n_upd - base, 16'h2);
        wr(`OFF_JIT_CONFIG, 8'hFB);
        rd(`OFF_JIT_CONFIG, d);
        chk("jit_cfg", d, 8'h03);
        chk("band_hi", o_jitter.band_select, 1'b1);
        chk("mode_auto", o_jitter.period_mode, 1'b1);
        base = n_upd;
        repeat (2 * SEC) @(posedge i_clk);
        chk("auto_period", n_upd - base, 16'h2);
        wr(`OFF_JIT_CONFIG, 8'h00);
        @(posedge i_clk);
        chk("band_lo", o_jitter.band_select, 1'b0);
        chk("mode_man", o_jitter.period_mode, 1'b0);
        give_verdict();
    end
endmodule

// File: rtl/line_err_params.svh
// Constants for the line error and jitter status register slice
`ifndef LINE_ERR_PARAMS_SVH
`define LINE_ERR_PARAMS_SVH
`define ADDR_W 11
`define DATA_W 8
`define CNT_W 16
`define OFF_IRQ_STATUS 11'h022
`define OFF_COUNT_LOW 11'h023
`define OFF_COUNT_HIGH 11'h024
`define OFF_JIT_CONFIG 11'h7E5
`define OFF_IRQ_MASK 11'h02A
`define OFF_COUNT_CTRL 11'h02B
`define BIT_SBPV 5
`define BIT_LBPV 4
`define BIT_SEXZ 3
`define BIT_LEXZ 2
`define BIT_PAT 1
`define BIT_CNTOV 0
`define STATUS_USED 8'h3F
`define BIT_CNT_MODE 1
`define BIT_CNT_NOW 0
`define CTRL_KEEP 8'h02
`define BIT_JIT_STOP 2
`define BIT_JIT_MODE 1
`define BIT_JIT_BAND 0
`define JIT_KEEP 8'h07
`define RESET_BYTE 8'h00
`define COUNT_RESET 16'h0000
`define COUNT_ONE 16'h0001
`define COUNT_MAX 16'hFFFF
`define LOW_LSB 0
`define HIGH_LSB 8
`define ONE_SECOND_NS 1000000000
`define CLK_PERIOD_NS 40
`endif

// File: rtl/line_err_pkg.sv
// Types shared by the line error and jitter status register slice
package line_err_pkg;
    typedef struct packed {
        logic sys_bpv;
        logic line_bpv;
        logic sys_exz;
        logic line_exz;
        logic pattern_err;
    } line_event_type;

    typedef struct packed {
        logic update;
        logic period_mode;
        logic band_select;
    } jitter_ctrl_type;
endpackage

// File: rtl/line_error_jitter_status_regs.sv
// Error event status, error counter and channel 0 jitter control registers
// Function
// (RULE1) Status bits stay set after their event until software writes a one.
// (RULE2) Status bit 5 flags system-side bipolar violation, bit 4 line side.
// (RULE3) Status bit 3 flags system-side excess zeros, bit 2 line side.
// (RULE4) Status bit 1 sets on a test-pattern checker error.
// (RULE5) Status bit 0 sets when the 16-bit error counter overflows.
// (RULE6) Any set status bit drives the interrupt output; bits 7 and 6 reserved. Here a set bit drives it only while its mask_r bit is zero.
// (RULE7) Error count reads as low byte and high byte, read-only, reset zero.
// (RULE8) Count registers refresh automatically or manually per the mode bit.
// (RULE9) Software reads the count within the next round or loses it.
// (RULE10) A rising stop bit copies the peak results into the peak registers.
// (RULE11) Software clears the stop bit again before the next update.
// (RULE12) Period mode zero: software ends the measurement period with stop.
// (RULE13) Period mode one: the device times a one-second period itself.
// (RULE14) Band bit zero selects the low-corner measurement filter band.
// (RULE15) Band bit one selects the high-corner measurement filter band.
// (RULE16) Overflow fires when the error count passes its maximum in a round.
`timescale 1ns/1ps
`include "line_err_params.svh"

module line_error_jitter_status_regs #(
    parameter int SECOND_CYCLES = `ONE_SECOND_NS / `CLK_PERIOD_NS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic [`DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`DATA_W-1:0] o_rdata,
    input wire line_err_pkg::line_event_type i_events,
    input wire logic i_err_pulse,
    output line_err_pkg::jitter_ctrl_type o_jitter,
    output logic o_irq
);
    import line_err_pkg::*;

    localparam int SEC_W = (SECOND_CYCLES > 1) ? $clog2(SECOND_CYCLES) : 1;
    localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SECOND_CYCLES - 1);

    function automatic logic [`DATA_W-1:0] place_events(
        input line_event_type ev,
        input logic ovf
    );
        logic [`DATA_W-1:0] v;
        v = `RESET_BYTE;
        v[`BIT_SBPV] = ev.sys_bpv;
        v[`BIT_LBPV] = ev.line_bpv;
        v[`BIT_SEXZ] = ev.sys_exz;
        v[`BIT_LEXZ] = ev.line_exz;
        v[`BIT_PAT] = ev.pattern_err;
        v[`BIT_CNTOV] = ovf;
        return v;
    endfunction

    function automatic logic hit(
        input logic [`ADDR_W-1:0] a,
        input logic [`ADDR_W-1:0] off
    );
        return a == off;
    endfunction

    logic [`DATA_W-1:0] status_r;
    logic [`DATA_W-1:0] status_nxt;
    logic [`DATA_W-1:0] mask_r;
    logic [`DATA_W-1:0] ctrl_r;
    logic [`DATA_W-1:0] jit_cfg_r;
    logic [`DATA_W-1:0] rdata_r;
    logic [`CNT_W-1:0] acc_r;
    logic [`CNT_W-1:0] acc_nxt;
    logic [`CNT_W-1:0] count_value_r;
    logic [SEC_W-1:0] sec_cnt_r;
    logic stop_prev_r;
    logic jit_update_r;

    wire wr_status = i_wr && hit(i_addr, `OFF_IRQ_STATUS);
    wire wr_mask = i_wr && hit(i_addr, `OFF_IRQ_MASK);
    wire wr_ctrl = i_wr && hit(i_addr, `OFF_COUNT_CTRL);
    wire wr_jit = i_wr && hit(i_addr, `OFF_JIT_CONFIG);

    // One-second timebase shared by auto counting rounds and jitter periods
    wire sec_tick = (sec_cnt_r == SEC_LAST);

    wire count_manual = ctrl_r[`BIT_CNT_MODE];
    wire manual_now = wr_ctrl && i_wdata[`BIT_CNT_NOW];
    wire round_end = count_manual ? manual_now : sec_tick; // RULE8
    wire acc_full = (acc_r == `COUNT_MAX);
    // Saturate rather than wrap so an overflowed round never reads small
    wire overflow = i_err_pulse && acc_full && !round_end; // RULE16

    wire [`DATA_W-1:0] set_vec = place_events(i_events, overflow); // RULE2 RULE3 RULE4 RULE5
    wire [`DATA_W-1:0] clr_vec = wr_status ? i_wdata : `RESET_BYTE;

    // Set wins over a clear in the same cycle
    assign status_nxt = ((status_r & ~clr_vec) | set_vec) & `STATUS_USED; // RULE1

    always_comb
    begin
        if (round_end)
        begin
            acc_nxt = i_err_pulse ? `COUNT_ONE : `COUNT_RESET;
        end
        else if (i_err_pulse && !acc_full)
        begin
            acc_nxt = acc_r + `COUNT_ONE;
        end
        else
        begin
            acc_nxt = acc_r;
        end
    end

    wire jit_auto = jit_cfg_r[`BIT_JIT_MODE];
    wire stop_rise = jit_cfg_r[`BIT_JIT_STOP] && !stop_prev_r;
    // Stop only acts in manual period mode; auto mode uses the timebase
    wire jit_period_end = jit_auto ? sec_tick : stop_rise; // RULE10 RULE12 RULE13

    wire [`DATA_W-1:0] count_low = count_value_r[`LOW_LSB +: `DATA_W];
    wire [`DATA_W-1:0] count_high = count_value_r[`HIGH_LSB +: `DATA_W];

    wire [`DATA_W-1:0] rd_sel =
        hit(i_addr, `OFF_IRQ_STATUS) ? status_r :
        hit(i_addr, `OFF_COUNT_LOW) ? count_low :
        hit(i_addr, `OFF_COUNT_HIGH) ? count_high :
        hit(i_addr, `OFF_JIT_CONFIG) ? jit_cfg_r :
        hit(i_addr, `OFF_IRQ_MASK) ? mask_r :
        hit(i_addr, `OFF_COUNT_CTRL) ? ctrl_r :
        `RESET_BYTE; // RULE7

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            status_r <= `RESET_BYTE;
            mask_r <= `RESET_BYTE;
        end
        else
        begin
            status_r <= status_nxt;
            if (wr_mask)
            begin
                mask_r <= i_wdata & `STATUS_USED;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ctrl_r <= `RESET_BYTE;
            jit_cfg_r <= `RESET_BYTE;
            stop_prev_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= i_wdata & `CTRL_KEEP;
            end
            if (wr_jit)
            begin
                jit_cfg_r <= i_wdata & `JIT_KEEP; // RULE14 RULE15
            end
            stop_prev_r <= jit_cfg_r[`BIT_JIT_STOP];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            acc_r <= `COUNT_RESET;
            count_value_r <= `COUNT_RESET;
        end
        else
        begin
            acc_r <= acc_nxt;
            if (round_end)
            begin
                count_value_r <= acc_r; // RULE8
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sec_cnt_r <= '0;
            jit_update_r <= 1'b0;
            rdata_r <= `RESET_BYTE;
        end
        else
        begin
            sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 1'b1;
            jit_update_r <= jit_period_end; // RULE10
            rdata_r <= i_rd ? rd_sel : `RESET_BYTE;
        end
    end

    assign o_rdata = rdata_r;
    // One driver for the whole struct, fields msb first
    assign o_jitter = {jit_update_r, jit_cfg_r[`BIT_JIT_MODE], jit_cfg_r[`BIT_JIT_BAND]};
    assign o_irq = |(status_r & ~mask_r); // RULE6

    // Checks
    logic [`CNT_W-1:0] acc_before_r;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            acc_before_r <= `COUNT_RESET;
        end
        else
        begin
            acc_before_r <= acc_r;
        end
    end

    property p_status_hold;
        @(posedge i_clk) disable iff (i_reset)
        (status_r[`BIT_SBPV] && !(wr_status && i_wdata[`BIT_SBPV]))
        |=> status_r[`BIT_SBPV];
    endproperty
    a_status_hold: assert property (p_status_hold) // RULE1
        else $error("status bit dropped without a clear");

    property p_status_clear;
        @(posedge i_clk) disable iff (i_reset)
        (wr_status && i_wdata[`BIT_LEXZ] && !i_events.line_exz)
        |=> !status_r[`BIT_LEXZ];
    endproperty
    a_status_clear: assert property (p_status_clear) // RULE1
        else $error("write one did not clear status bit");

    property p_bpv_set;
        @(posedge i_clk) disable iff (i_reset)
        (i_events.sys_bpv || i_events.line_bpv)
        |=> (status_r[`BIT_SBPV] == $past(i_events.sys_bpv)
             || $past(status_r[`BIT_SBPV]))
            && (status_r[`BIT_LBPV] || !$past(i_events.line_bpv));
    endproperty
    a_bpv_set: assert property (p_bpv_set) // RULE2
        else $error("bipolar violation flag not set");

    property p_exz_set;
        @(posedge i_clk) disable iff (i_reset)
        i_events.sys_exz |=> status_r[`BIT_SEXZ];
    endproperty
    a_exz_set: assert property (p_exz_set) // RULE3
        else $error("excess zeros flag not set");

    property p_pat_set;
        @(posedge i_clk) disable iff (i_reset)
        (i_events.pattern_err && wr_status && i_wdata[`BIT_PAT])
        |=> status_r[`BIT_PAT];
    endproperty
    a_pat_set: assert property (p_pat_set) // RULE4
        else $error("pattern error lost against a clear");

    sequence s_count_at_max;
        acc_r == `COUNT_MAX && i_err_pulse && !round_end;
    endsequence

    property p_overflow;
        @(posedge i_clk) disable iff (i_reset)
        s_count_at_max |=> status_r[`BIT_CNTOV] && acc_r == `COUNT_MAX;
    endproperty
    a_overflow: assert property (p_overflow) // RULE5
        else $error("overflow not flagged at maximum count");

    property p_irq;
        @(posedge i_clk) disable iff (i_reset)
        (i_events.sys_exz && !mask_r[`BIT_SEXZ] && !wr_mask) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) // RULE6
        else $error("unmasked event did not raise interrupt");

    property p_reserved;
        @(posedge i_clk) disable iff (i_reset)
        (i_rd && hit(i_addr, `OFF_IRQ_STATUS))
        |=> (o_rdata & ~`STATUS_USED) == `RESET_BYTE;
    endproperty
    a_reserved: assert property (p_reserved) // RULE6
        else $error("reserved status bits read nonzero");

    property p_count_read;
        @(posedge i_clk) disable iff (i_reset)
        (i_rd && hit(i_addr, `OFF_COUNT_HIGH) && !round_end)
        |=> o_rdata == count_value_r[`HIGH_LSB +: `DATA_W];
    endproperty
    a_count_read: assert property (p_count_read) // RULE7
        else $error("high count byte read wrong");

    property p_round_latch;
        @(posedge i_clk) disable iff (i_reset)
        round_end |=> count_value_r == acc_before_r;
    endproperty
    a_round_latch: assert property (p_round_latch) // RULE8
        else $error("count not latched at round end");

    property p_auto_round;
        @(posedge i_clk) disable iff (i_reset)
        (!count_manual && !sec_tick) |=> $stable(count_value_r);
    endproperty
    a_auto_round: assert property (p_auto_round) // RULE8
        else $error("auto count changed between rounds");

    sequence s_stop_write;
        wr_jit && i_wdata[`BIT_JIT_STOP] && !i_wdata[`BIT_JIT_MODE]
        && !jit_cfg_r[`BIT_JIT_STOP] && !(jit_auto && sec_tick);
    endsequence

    property p_stop_update;
        @(posedge i_clk) disable iff (i_reset)
        s_stop_write |=> !o_jitter.update ##1 o_jitter.update;
    endproperty
    a_stop_update: assert property (p_stop_update) // RULE10
        else $error("stop rise did not update peaks");

    property p_manual_only;
        @(posedge i_clk) disable iff (i_reset)
        (!jit_auto && !stop_rise) |=> !o_jitter.update;
    endproperty
    a_manual_only: assert property (p_manual_only) // RULE12
        else $error("update without stop rise in manual mode");

    property p_auto_period;
        @(posedge i_clk) disable iff (i_reset)
        (jit_auto && sec_tick && !wr_jit) |=> o_jitter.update ##1 !o_jitter.update;
    endproperty
    a_auto_period: assert property (p_auto_period) // RULE13
        else $error("auto period update missing");

    property p_tick_spacing;
        @(posedge i_clk) disable iff (i_reset)
        sec_tick |=> sec_cnt_r == '0;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) // RULE13
        else $error("timebase did not restart");

    property p_band;
        @(posedge i_clk) disable iff (i_reset)
        wr_jit |=> o_jitter.band_select == $past(i_wdata[`BIT_JIT_BAND]);
    endproperty
    a_band: assert property (p_band) // RULE14 RULE15
        else $error("band select not taken from write");

    property p_lexz_set;
        @(posedge i_clk) disable iff (i_reset)
        i_events.line_exz |=> status_r[`BIT_LEXZ];
    endproperty
    a_lexz_set: assert property (p_lexz_set) // RULE3
        else $error("line excess zeros flag not set");

    property p_lbpv_set;
        @(posedge i_clk) disable iff (i_reset)
        i_events.line_bpv |=> status_r[`BIT_LBPV];
    endproperty
    a_lbpv_set: assert property (p_lbpv_set) // RULE2
        else $error("line bipolar violation flag not set");

    property p_count_low;
        @(posedge i_clk) disable iff (i_reset)
        (i_rd && hit(i_addr, `OFF_COUNT_LOW) && !round_end)
        |=> o_rdata == count_value_r[`LOW_LSB +: `DATA_W];
    endproperty
    a_count_low: assert property (p_count_low) // RULE7
        else $error("low count byte read wrong");

    // Idle read data stay zero so a stale byte is never mistaken for an answer
    property p_rdata_idle;
        @(posedge i_clk) disable iff (i_reset)
        !i_rd |=> o_rdata == `RESET_BYTE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // RULE7
        else $error("read data not zero outside a read");

endmodule
